// file: common/rtc_irq_regs.svh
`ifndef RTC_IRQ_REGS_SVH
`define RTC_IRQ_REGS_SVH

// Register indexes, byte address is four times the index
`define CTRL_IDX 23'h1FFFF6
`define FLAGS_IDX 23'h1FFFE0
`define MASK_IDX 23'h1FFFE1

// Reset values
`define CTRL_RESET 8'h00
`define MASK_RESET 3'h0
`define FLAGS_RESET 3'h0

// Control register field positions
`define BIT_WATCHDOG_IRQ_ENABLE 7
`define BIT_ALARM_IRQ_ENABLE 6
`define BIT_POWERFAIL_IRQ_ENABLE 5
`define BIT_SQUARE_WAVE_ENABLE 4
`define BIT_ACTIVE_HIGH 3
`define BIT_PULSE_MODE 2
`define BIT_WAVE_FREQ_SELECT_HI 1
`define BIT_WAVE_FREQ_SELECT_LO 0

// Flags and mask field positions
`define FLAG_WATCHDOG 0
`define FLAG_ALARM 1
`define FLAG_POWERFAIL 2
`define FLAG_COUNT 3

// Timing
`define SYS_CLK_HZ 10000000
`define PULSE_TIME_MS 200
`define PULSE_CYCLES (`PULSE_TIME_MS * (`SYS_CLK_HZ / 1000))

// Time base tick rate and half periods in ticks per frequency
`define WAVE_TICK_HZ 65536
`define WAVE_HZ_SLOW 1
`define WAVE_HZ_512 512
`define WAVE_HZ_4096 4096
`define WAVE_HZ_FAST 32768
`define HALF_TICKS(f) (`WAVE_TICK_HZ / (2 * (f)))

`endif

// file: common/rtc_irq_pkg.sv
package rtc_irq_pkg;

	// Square wave frequency selection, codes 00 to 11
	typedef enum logic [1:0] {
		FREQ_SLOW,
		FREQ_512,
		FREQ_4096,
		FREQ_FAST
	} wave_freq_t;

	// Interrupt pin state
	typedef enum logic [1:0] {
		PIN_IDLE,
		PIN_PULSE,
		PIN_LEVEL
	} pin_state_t;

endpackage

// file: common/irq_ctrl_if.sv
`timescale 1ns/1ps
interface irq_ctrl_if;
	logic osc_tick;
	rtc_irq_pkg::wave_freq_t freq_sel;
	logic wave_en;
	logic wave;
	logic pulse_start;
	logic pulse_busy;

	modport wave_side (input osc_tick, input freq_sel, input wave_en, output wave);
	modport timer_side (input pulse_start, output pulse_busy);
	modport ctrl_side (output osc_tick, output freq_sel, output wave_en, output pulse_start,
		input wave, input pulse_busy);
endinterface

// file: hdl/square_wave_gen.sv
`timescale 1ns/1ps
`include "rtc_irq_regs.svh"
module square_wave_gen #(
	parameter int CNT_W = 16
) (
	// Clock and reset
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	// Control side
	irq_ctrl_if.wave_side link
);
	localparam logic [CNT_W-1:0] HALF_SLOW = CNT_W'(`HALF_TICKS(`WAVE_HZ_SLOW));
	localparam logic [CNT_W-1:0] HALF_512 = CNT_W'(`HALF_TICKS(`WAVE_HZ_512));
	localparam logic [CNT_W-1:0] HALF_4096 = CNT_W'(`HALF_TICKS(`WAVE_HZ_4096));
	localparam logic [CNT_W-1:0] HALF_FAST = CNT_W'(`HALF_TICKS(`WAVE_HZ_FAST));

	// Counter must hold the longest half period
	if ((2 ** CNT_W) <= `HALF_TICKS(`WAVE_HZ_SLOW)) begin : g_chk
		$error("square_wave_gen: CNT_W too small");
	end

	logic [CNT_W-1:0] cnt_q, cnt_d, half;
	logic wave_q, wave_d;

	// Half period from frequency selection
	always_comb begin
		unique case (link.freq_sel)
			rtc_irq_pkg::FREQ_SLOW: half = HALF_SLOW;
			rtc_irq_pkg::FREQ_512: half = HALF_512;
			rtc_irq_pkg::FREQ_4096: half = HALF_4096;
			rtc_irq_pkg::FREQ_FAST: half = HALF_FAST;
		endcase
	end

	// Toggle after each half period, idle low when disabled
	always_comb begin
		cnt_d = cnt_q;
		wave_d = wave_q;
		if (!link.wave_en) begin
			cnt_d = '0;
			wave_d = 1'b0;
		end else if (link.osc_tick) begin
			if (cnt_q >= half - CNT_W'(1)) begin
				cnt_d = '0;
				wave_d = ~wave_q;
			end else begin
				cnt_d = cnt_q + CNT_W'(1);
			end
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			cnt_q <= '0;
			wave_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			wave_q <= wave_d;
		end
	end

	assign link.wave = wave_q;
endmodule

// file: hdl/pulse_timer.sv
`timescale 1ns/1ps
module pulse_timer #(
	parameter int PULSE_CYCLES = 2000000
) (
	// Clock and reset
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	// Control side
	irq_ctrl_if.timer_side link
);
	localparam int CW = $clog2(PULSE_CYCLES + 1);

	if (PULSE_CYCLES < 8) begin : g_chk
		$error("pulse_timer: PULSE_CYCLES below 8");
	end

	logic [CW-1:0] cnt_q, cnt_d;

	// Load on start, restart on a new start, count down to zero
	always_comb begin
		cnt_d = cnt_q;
		if (link.pulse_start) begin
			cnt_d = CW'(PULSE_CYCLES);
		end else if (cnt_q != '0) begin
			cnt_d = cnt_q - CW'(1);
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	assign link.pulse_busy = (cnt_q != '0);
endmodule

// file: hdl/rtc_interrupt_output_control.sv
// Functional notes
// - Enabled watchdog timeout drives pin, sets flag
// - Disabled watchdog timeout only sets flag
// - Alarm match drives pin when enabled, flags
// - Square wave enable drives selected wave
// - Square wave wins over interrupt logic
// - During wave, events only set flags
// - Pulse mode holds pin about 200 ms
// - Level mode holds pin until flags read
`timescale 1ns/1ps
`include "rtc_irq_regs.svh"
module rtc_interrupt_output_control #(
	parameter int ADDR_W = 25,
	parameter int PULSE_CYCLES = `PULSE_CYCLES
) (
	// Clock and reset
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	// Wishbone slave
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [ADDR_W-1:0] i_wb_adr,
	input wire logic [31:0] i_wb_dat,
	input wire logic [3:0] i_wb_sel,
	output logic [31:0] o_wb_dat,
	output logic o_wb_ack,
	// Oscillator time base, one-cycle strobe at 65.536 kHz
	input wire logic i_osc_tick,
	// Event strobes
	input wire logic i_watchdog_timeout,
	input wire logic i_alarm_match,
	input wire logic i_powerfail_detect,
	// Interrupt pin
	output logic o_int_o,
	output logic o_int_oe,
	// System interrupt
	output logic o_irq
);
	if (ADDR_W != 25) begin : g_chk
		$error("rtc_interrupt_output_control: ADDR_W must be 25");
	end

	irq_ctrl_if u_link ();

	logic [7:0] ctrl_q, ctrl_d;
	logic [`FLAG_COUNT-1:0] flags_q, flags_d, mask_q, mask_d, ev, en_ev;
	logic ack_q, ack_d;
	logic [31:0] rdat_q, rdat_d;
	logic irq_q, irq_d;
	logic int_o_q, int_o_d, int_oe_q, int_oe_d;
	rtc_irq_pkg::pin_state_t state_q, state_d;
	logic req, commit, hit_ctrl, hit_flags, hit_mask, flags_read, fire;
	logic wave_on, active_high, pulse_mode, pin_active;

	// Submodules
	square_wave_gen u_wave (
		.i_sys_clk(i_sys_clk),
		.i_rst_n(i_rst_n),
		.link(u_link.wave_side)
	);

	pulse_timer #(
		.PULSE_CYCLES(PULSE_CYCLES)
	) u_timer (
		.i_sys_clk(i_sys_clk),
		.i_rst_n(i_rst_n),
		.link(u_link.timer_side)
	);

	// Control field decode
	assign wave_on = ctrl_q[`BIT_SQUARE_WAVE_ENABLE];
	assign active_high = ctrl_q[`BIT_ACTIVE_HIGH];
	assign pulse_mode = ctrl_q[`BIT_PULSE_MODE];

	// Event vector and enabled events
	assign ev[`FLAG_WATCHDOG] = i_watchdog_timeout;
	assign ev[`FLAG_ALARM] = i_alarm_match;
	assign ev[`FLAG_POWERFAIL] = i_powerfail_detect;
	assign en_ev[`FLAG_WATCHDOG] = i_watchdog_timeout & ctrl_q[`BIT_WATCHDOG_IRQ_ENABLE];
	assign en_ev[`FLAG_ALARM] = i_alarm_match & ctrl_q[`BIT_ALARM_IRQ_ENABLE];
	assign en_ev[`FLAG_POWERFAIL] = i_powerfail_detect & ctrl_q[`BIT_POWERFAIL_IRQ_ENABLE];
	// Pin action suppressed while the wave owns the pin
	assign fire = (|en_ev) & ~wave_on;

	// Links to submodules
	assign u_link.osc_tick = i_osc_tick;
	assign u_link.wave_en = wave_on;
	assign u_link.freq_sel = rtc_irq_pkg::wave_freq_t'({ctrl_q[`BIT_WAVE_FREQ_SELECT_HI],
		ctrl_q[`BIT_WAVE_FREQ_SELECT_LO]});
	assign u_link.pulse_start = fire & pulse_mode;

	// Bus decode
	assign req = i_wb_cyc & i_wb_stb;
	assign commit = req & ack_q;
	assign hit_ctrl = (i_wb_adr[ADDR_W-1:2] == `CTRL_IDX);
	assign hit_flags = (i_wb_adr[ADDR_W-1:2] == `FLAGS_IDX);
	assign hit_mask = (i_wb_adr[ADDR_W-1:2] == `MASK_IDX);
	assign flags_read = commit & ~i_wb_we & hit_flags;

	// Bus answer, one wait cycle, unmapped reads return zero
	always_comb begin
		ack_d = req & ~ack_q;
		rdat_d = rdat_q;
		if (req & ~ack_q) begin
			if (hit_ctrl) begin
				rdat_d = {24'h000000, ctrl_q};
			end else if (hit_flags) begin
				rdat_d = {29'h00000000, flags_q};
			end else if (hit_mask) begin
				rdat_d = {29'h00000000, mask_q};
			end else begin
				rdat_d = 32'h00000000;
			end
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			ack_q <= 1'b0;
			rdat_q <= 32'h00000000;
		end else begin
			ack_q <= ack_d;
			rdat_q <= rdat_d;
		end
	end

	// Registers: writes at the acknowledged edge, flags cleared by read, set wins
	always_comb begin
		ctrl_d = ctrl_q;
		mask_d = mask_q;
		flags_d = flags_q;
		if (commit & i_wb_we & i_wb_sel[0]) begin
			if (hit_ctrl) begin
				ctrl_d = i_wb_dat[7:0];
			end
			if (hit_mask) begin
				mask_d = i_wb_dat[`FLAG_COUNT-1:0];
			end
		end
		if (flags_read) begin
			flags_d = flags_q & ~rdat_q[`FLAG_COUNT-1:0]; // Keeps events newer than the capture
		end
		flags_d = flags_d | ev;
		irq_d = |(flags_d & mask_d);
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			ctrl_q <= `CTRL_RESET;
			mask_q <= `MASK_RESET;
			flags_q <= `FLAGS_RESET;
			irq_q <= 1'b0;
		end else begin
			ctrl_q <= ctrl_d;
			mask_q <= mask_d;
			flags_q <= flags_d;
			irq_q <= irq_d;
		end
	end

	// Pin state: pulse until timer ends, level until flags read
	always_comb begin
		state_d = state_q;
		if (fire) begin
			state_d = pulse_mode ? rtc_irq_pkg::PIN_PULSE : rtc_irq_pkg::PIN_LEVEL;
		end else begin
			unique case (state_q)
				rtc_irq_pkg::PIN_IDLE: state_d = rtc_irq_pkg::PIN_IDLE;
				rtc_irq_pkg::PIN_PULSE: begin
					if (!u_link.pulse_busy) begin
						state_d = rtc_irq_pkg::PIN_IDLE;
					end
				end
				rtc_irq_pkg::PIN_LEVEL: begin
					if (flags_read) begin
						state_d = rtc_irq_pkg::PIN_IDLE;
					end
				end
				default: state_d = rtc_irq_pkg::PIN_IDLE;
			endcase
		end
	end

	assign pin_active = (state_q != rtc_irq_pkg::PIN_IDLE);

	// Pin drive: wave first, then interrupt, by polarity style
	always_comb begin
		if (active_high) begin
			int_oe_d = 1'b1;
			int_o_d = wave_on ? u_link.wave : pin_active;
		end else begin
			int_o_d = 1'b0;
			int_oe_d = wave_on ? ~u_link.wave : pin_active;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			state_q <= rtc_irq_pkg::PIN_IDLE;
			int_o_q <= 1'b0;
			int_oe_q <= 1'b0;
		end else begin
			state_q <= state_d;
			int_o_q <= int_o_d;
			int_oe_q <= int_oe_d;
		end
	end

	assign o_wb_ack = ack_q;
	assign o_wb_dat = rdat_q;
	assign o_irq = irq_q;
	assign o_int_o = int_o_q;
	assign o_int_oe = int_oe_q;

	// Checks
	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (!i_rst_n);

	a_wdog_pin_fire: assert property (i_watchdog_timeout && ctrl_q[`BIT_WATCHDOG_IRQ_ENABLE]
		&& !wave_on |=> pin_active && flags_q[`FLAG_WATCHDOG] ##1 (o_int_o == active_high
		|| $past(ctrl_q) != ctrl_q))
		else $error("watchdog timeout did not drive the pin");

	a_wdog_flag_only: assert property (i_watchdog_timeout && !ctrl_q[`BIT_WATCHDOG_IRQ_ENABLE]
		&& !(|en_ev) && state_q == rtc_irq_pkg::PIN_IDLE
		|=> state_q == rtc_irq_pkg::PIN_IDLE && flags_q[`FLAG_WATCHDOG])
		else $error("disabled watchdog timeout touched the pin");

	a_alarm_pin_fire: assert property (i_alarm_match && ctrl_q[`BIT_ALARM_IRQ_ENABLE] && !wave_on
		|=> pin_active && flags_q[`FLAG_ALARM])
		else $error("alarm match did not drive the pin");

	a_pfail_pin_fire: assert property (i_powerfail_detect && ctrl_q[`BIT_POWERFAIL_IRQ_ENABLE]
		&& !wave_on |=> pin_active && flags_q[`FLAG_POWERFAIL])
		else $error("power-fail did not drive the pin");

	a_wave_on_pin: assert property (wave_on && active_high && $stable(ctrl_q)
		|=> o_int_o == $past(u_link.wave) && o_int_oe)
		else $error("square wave not on the pin");

	a_wave_over_irq: assert property (wave_on && !active_high && $stable(ctrl_q) && pin_active
		|=> o_int_oe == !$past(u_link.wave))
		else $error("interrupt overrode the square wave");

	a_wave_flag_only: assert property (wave_on && (|en_ev)
		|=> state_q == $past(state_q) && (flags_q & $past(ev)) == $past(ev))
		else $error("event during square wave changed the pin state");

	a_open_drain: assert property (!active_high |=> !o_int_o)
		else $error("open-drain pin driven high");

	a_pulse_hold: assert property ($rose(u_link.pulse_busy) |-> u_link.pulse_busy[*8])
		else $error("pulse released too early");

	a_level_hold: assert property (state_q == rtc_irq_pkg::PIN_LEVEL && !flags_read && !fire
		|=> state_q == rtc_irq_pkg::PIN_LEVEL)
		else $error("level interrupt released without a flags read");

	a_fast_wave: assert property (wave_on && $stable(ctrl_q) && u_link.freq_sel ==
		rtc_irq_pkg::FREQ_FAST && $past(wave_on) && i_osc_tick
		|=> u_link.wave != $past(u_link.wave))
		else $error("fastest wave did not toggle each tick");
endmodule

// file: tb/host_pin_model.sv
`timescale 1ns/1ps
module host_pin_model (
	// Pin from the block
	input wire logic i_int_o,
	input wire logic i_int_oe,
	// Level the host senses
	output logic o_pin_level
);
	// Pull-up holds the released pin high
	assign o_pin_level = i_int_oe ? i_int_o : 1'h1;
endmodule

// file: tb/test_rtc_interrupt_output_control.sv
`timescale 1ns/1ps
`include "rtc_irq_regs.svh"
module test_rtc_interrupt_output_control;
	localparam int P = 40;
	localparam logic [24:0] A_CTRL = {`CTRL_IDX, 2'h0};
	localparam logic [24:0] A_FLAGS = {`FLAGS_IDX, 2'h0};
	localparam logic [24:0] A_MASK = {`MASK_IDX, 2'h0};
	logic clk = 1'h0;
	logic rst_n = 1'h0;
	logic cyc = 1'h0;
	logic stb = 1'h0;
	logic we = 1'h0;
	logic [24:0] adr = 25'h0;
	logic [31:0] wdat = 32'h0;
	logic [3:0] sel = 4'h0;
	logic tick = 1'h0;
	logic [2:0] ev = 3'h0;
	logic [31:0] rdat;
	logic [31:0] q;
	logic ack;
	logic int_o;
	logic int_oe;
	logic irq;
	logic pin;
	int tcnt = 0;
	int num_errors = 0;
	int n_tests = 0;

	rtc_interrupt_output_control #(.PULSE_CYCLES(P)) DUT (.i_sys_clk(clk), .i_rst_n(rst_n),
		.i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(wdat),
		.i_wb_sel(sel), .o_wb_dat(rdat), .o_wb_ack(ack), .i_osc_tick(tick),
		.i_watchdog_timeout(ev[0]), .i_alarm_match(ev[1]), .i_powerfail_detect(ev[2]),
		.o_int_o(int_o), .o_int_oe(int_oe), .o_irq(irq));
	host_pin_model host (.i_int_o(int_o), .i_int_oe(int_oe), .o_pin_level(pin));

	// Clock, 100 ns period
	initial begin
		forever #50 clk = ~clk;
	end

	// Time base strobe every fourth cycle
	always @(posedge clk) begin
		tcnt <= (tcnt + 1) % 4;
		tick <= (tcnt == 3);
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
			num_errors++;
		end
	endtask

	// Classic single Wishbone cycle, waits for ack
	task automatic wb(input logic w, input logic [24:0] a, input logic [7:0] d,
		output logic [31:0] r);
		int n;
		n = 0;
		cyc <= 1'h1;
		stb <= 1'h1;
		we <= w;
		adr <= a;
		wdat <= {24'h0, d};
		sel <= 4'hF;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'h1 && n < 50);
		r = rdat;
		if (n >= 50) num_errors++;
		cyc <= 1'h0;
		stb <= 1'h0;
		@(posedge clk);
	endtask

	task automatic fire(input int i);
		ev[i] <= 1'h1;
		@(posedge clk);
		ev <= 3'h0;
	endtask

	// Cycles between two pin changes
	task automatic half(output int c);
		logic p;
		int n;
		n = 0;
		c = 0;
		p = pin;
		while (pin === p && n < 2000) begin
			@(posedge clk);
			n++;
		end
		p = pin;
		while (pin === p && c < 2000) begin
			@(posedge clk);
			c++;
		end
	endtask

	task automatic t_reset();
		chk({int_oe, pin, irq}, 32'h2);
		wb(1'h0, A_CTRL, 8'h00, q);
		chk(q, 32'h0);
		wb(1'h1, A_FLAGS, 8'h07, q);
		wb(1'h0, A_FLAGS, 8'h00, q);
		chk(q, 32'h0);
		wb(1'h1, 25'h100, 8'hFF, q);
		wb(1'h0, 25'h100, 8'h00, q);
		chk(q, 32'h0);
		wb(1'h1, A_MASK, 8'h03, q);
		wb(1'h0, A_MASK, 8'h00, q);
		chk(q, 32'h3);
		wb(1'h1, A_CTRL, 8'hA5, q);
		wb(1'h0, A_CTRL, 8'h00, q);
		chk(q, 32'hA5);
		$display("reset test done");
	endtask

	// Every source, enabled or not, both pin styles
	task automatic t_level();
		for (int h = 0; h < 2; h++) begin
			for (int e = 0; e < 2; e++) begin
				for (int i = 0; i < 3; i++) begin
					wb(1'h1, A_CTRL, 8'(h * 8) | (e == 1 ? 8'(8'h80 >> i) : 8'h00), q);
					fire(i);
					repeat (3) @(posedge clk);
					chk(pin, e == h);
					chk(irq, i != 2);
					wb(1'h0, A_FLAGS, 8'h00, q);
					chk(q, 32'h1 << i);
					repeat (3) @(posedge clk);
					chk(pin, h == 0);
					chk(irq, 32'h0);
				end
			end
		end
		$display("level test done");
	endtask

	task automatic t_pulse();
		int n;
		n = 0;
		wb(1'h1, A_CTRL, 8'h8C, q);
		fire(0);
		while (pin !== 1'h1 && n < 10) begin
			@(posedge clk);
			n++;
		end
		n = 0;
		while (pin === 1'h1 && n < 4 * P) begin
			@(posedge clk);
			n++;
		end
		chk(n >= P - 2 && n <= P + 3, 32'h1);
		wb(1'h0, A_FLAGS, 8'h00, q);
		chk(q, 32'h1);
		$display("pulse test done");
	endtask

	task automatic t_wave();
		int c;
		for (int k = 1; k < 4; k++) begin
			wb(1'h1, A_CTRL, 8'hF8 | 8'(k), q);
			fire(k - 1);
			half(c);
			chk(c, k == 1 ? 256 : (k == 2 ? 32 : 4));
		end
		wb(1'h1, A_CTRL, 8'h08, q);
		wb(1'h1, A_CTRL, 8'hF8, q);
		c = 0;
		repeat (600) begin
			@(posedge clk);
			c += (pin !== 1'h0);
		end
		chk(c, 32'h0);
		wb(1'h0, A_FLAGS, 8'h00, q);
		chk(q, 32'h7);
		wb(1'h1, A_CTRL, 8'h08, q);
		repeat (3) @(posedge clk);
		chk(pin, 32'h0);
		// Open-drain wave over a pending level interrupt
		wb(1'h1, A_CTRL, 8'h80, q);
		fire(0);
		repeat (3) @(posedge clk);
		chk(pin, 32'h0);
		wb(1'h1, A_CTRL, 8'h93, q);
		half(c);
		chk(c, 32'h4);
		wb(1'h1, A_CTRL, 8'h80, q);
		repeat (3) @(posedge clk);
		chk(pin, 32'h0);
		wb(1'h0, A_FLAGS, 8'h00, q);
		chk(q, 32'h1);
		repeat (3) @(posedge clk);
		chk(pin, 32'h1);
		$display("wave test done");
	endtask

	task automatic give_verdict();
		$display("Checks %0d, mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// Watchdog against a hang
	initial begin
		repeat (20000) @(posedge clk);
		num_errors++;
		give_verdict();
	end

	// Main sequence
	initial begin
		repeat (12) @(posedge clk);
		rst_n <= 1'h1;
		t_reset();
		t_level();
		t_pulse();
		t_wave();
		give_verdict();
	end
endmodule
